/* File: logic/rotate_left_unit.sv */
/*
  Rotate-left datapath slice: sixteen working registers, a flag byte and
  the plain and through-carry rotate-left instructions, run from a command
  register. Assumes a classic Wishbone master on clk_i.
*/
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Plain rotate: bit 7 to bit0 and carry
// - Opcodes 90, 91 plain rotate, six cycles
// - Opcodes 10, 11 through carry; bit7 to carry
// - Through carry: old carry into bit 0
// - Zero flag set when result is zero
// - Overflow flag set when bit 7 changed
// - Sign flag follows result bit 7
// - Operand byte E plus working register nibble
module rotate_left_unit
  import rotl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Execution status
  output logic busy_o
);
  logic [7:0] rf_ff [16];
  flags_s flags_ff;
  logic busy_ff;
  logic [2:0] cnt_ff;
  logic op_plain_ff;
  logic [3:0] tgt_ff;
  logic bad_opc_ff;
  logic bad_dst_ff;
  logic [15:0] cmd_ff;
  logic ack_ff;
  logic [DATA_W-1:0] rdat_ff;

  // Bus decode
  // A held strobe is not taken twice: ack_ff masks the second cycle
  wire acc_w = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr_w = acc_w & wb_we_i;
  wire sel_cmd_w = (wb_adr_i == OFS_CMD);
  wire sel_flags_w = (wb_adr_i == OFS_FLAGS);
  wire sel_status_w = (wb_adr_i == OFS_STATUS);
  wire sel_wreg_w = (wb_adr_i[7:6] == OFS_WREG_TOP) && (wb_adr_i[1:0] == 2'h0);
  wire [3:0] wreg_idx_w = wb_adr_i[5:2];
  // Writes are refused while an instruction runs, so the operand stays put
  wire wr_ok_w = wr_w & ~busy_ff & wb_sel_i[0];

  // Command decode
  wire [7:0] opc_w = wb_dat_i[CMD_OPC_LSB +: 8];
  wire [7:0] dst_w = wb_dat_i[CMD_DST_LSB +: 8];
  wire opc_plain_w = (opc_w == OPC_ROTL_SLOT) || (opc_w == OPC_ROTL_PTR);
  wire opc_carry_w = (opc_w == OPC_ROTC_SLOT) || (opc_w == OPC_ROTC_PTR);
  // Odd opcodes reach the operand through a pointer register
  wire opc_ptr_w = opc_w[0];
  wire opc_ok_w = opc_plain_w | opc_carry_w;
  wire dst_ok_w = (dst_w[7:4] == WREG_MARK);
  wire cmd_wr_w = wr_ok_w & sel_cmd_w & wb_sel_i[1];
  wire start_w = cmd_wr_w & opc_ok_w & dst_ok_w;
  // Pointer mode: the named register holds the operand's register number
  // Only the pointer's low nibble counts: there are sixteen registers
  wire [3:0] ptr_w = rf_ff[dst_w[3:0]][3:0];
  wire [3:0] addr_w = opc_ptr_w ? ptr_w : dst_w[3:0];

  // Datapath
  wire [7:0] src_w = rf_ff[tgt_ff];
  wire bit0_w = op_plain_ff ? src_w[7] : flags_ff.c;
  wire [7:0] res_w = {src_w[6:0], bit0_w};
  // Last busy cycle: result and flags land at the next edge
  wire done_w = busy_ff && (cnt_ff == EXEC_LAST);
  // Flags come from the operand as it stood before write-back
  flags_s nxt_flags;
  always_comb begin
    nxt_flags = flags_ff;
    nxt_flags.c = src_w[7];
    nxt_flags.z = (res_w == 8'h00);
    nxt_flags.v = res_w[7] ^ src_w[7];
    nxt_flags.s = res_w[7];
  end

  // Read mux
  // Unmapped addresses read zero; writes to them are dropped
  wire [DATA_W-1:0] nxt_rdat =
    sel_cmd_w ? {16'h0000, cmd_ff} :
    sel_flags_w ? {24'h000000, flags_ff} :
    sel_status_w ? {29'h00000000, bad_dst_ff, bad_opc_ff, busy_ff} :
    sel_wreg_w ? {24'h000000, rf_ff[wreg_idx_w]} : '0;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff <= acc_w;
      rdat_ff <= (acc_w && !wb_we_i) ? nxt_rdat : '0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_ff <= 1'b0;
      cnt_ff <= 3'h0;
      op_plain_ff <= 1'b0;
      tgt_ff <= 4'h0;
      cmd_ff <= 16'h0000;
      bad_opc_ff <= 1'b0;
      bad_dst_ff <= 1'b0;
    end else if (start_w) begin
      busy_ff <= 1'b1;
      cnt_ff <= 3'h0;
      op_plain_ff <= opc_plain_w;
      tgt_ff <= addr_w;
      cmd_ff <= {dst_w, opc_w};
      bad_opc_ff <= 1'b0;
      bad_dst_ff <= 1'b0;
    end else if (cmd_wr_w) begin
      cmd_ff <= {dst_w, opc_w};
      bad_opc_ff <= ~opc_ok_w;
      bad_dst_ff <= ~dst_ok_w;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff + 3'h1;
      busy_ff <= ~done_w;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_ff <= FLAGS_RST;
    end else if (done_w) begin
      flags_ff <= nxt_flags;
    end else if (wr_ok_w && sel_flags_w) begin
      flags_ff <= flags_s'(wb_dat_i[7:0]);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 16; i++) begin
        rf_ff[i] <= 8'h00;
      end
    end else if (done_w) begin
      rf_ff[tgt_ff] <= res_w;
    end else if (wr_ok_w && sel_wreg_w) begin
      rf_ff[wreg_idx_w] <= wb_dat_i[7:0];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign busy_o = busy_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_plain_result: assert property (done_w && op_plain_ff |=>
    rf_ff[tgt_ff] == {$past(src_w[6:0]), $past(src_w[7])} && flags_ff.c == $past(src_w[7]))
    else $error("plain rotate result or carry wrong");
  chk_carry_in: assert property (done_w && !op_plain_ff |=>
    rf_ff[tgt_ff][0] == $past(flags_ff.c) && rf_ff[tgt_ff][7:1] == $past(src_w[6:0]))
    else $error("through-carry bit 0 not old carry");
  chk_carry_out: assert property (done_w && !op_plain_ff |=>
    flags_ff.c == $past(src_w[7]))
    else $error("through-carry carry not old bit 7");
  chk_exec_six: assert property (start_w |=> busy_ff [*6] ##1 !busy_ff)
    else $error("instruction did not take six cycles");
  chk_zero_flag: assert property (done_w |=> flags_ff.z == (rf_ff[tgt_ff] == 8'h00))
    else $error("zero flag wrong");
  chk_ovf_flag: assert property (done_w |=>
    flags_ff.v == (rf_ff[tgt_ff][7] ^ $past(src_w[7])))
    else $error("overflow flag wrong");
  chk_sign_flag: assert property (done_w |=> flags_ff.s == rf_ff[tgt_ff][7])
    else $error("sign flag wrong");
  chk_hd_kept: assert property (done_w |=>
    flags_ff.h == $past(flags_ff.h) && flags_ff.d == $past(flags_ff.d))
    else $error("half-carry or decimal flag disturbed");
  chk_bad_operand: assert property (cmd_wr_w && !busy_ff && !dst_ok_w |=>
    !busy_ff && bad_dst_ff)
    else $error("operand without E marker accepted");
  chk_bad_opcode: assert property (cmd_wr_w && !opc_ok_w |=>
    !busy_ff && bad_opc_ff)
    else $error("unknown opcode started");
  chk_slot_target: assert property (start_w && !opc_ptr_w |=>
    tgt_ff == $past(dst_w[3:0]))
    else $error("slot operand register wrong");
  chk_ptr_target: assert property (start_w && opc_ptr_w |=>
    tgt_ff == $past(rf_ff[dst_w[3:0]][3:0]))
    else $error("pointer operand register wrong");
  // While busy only write-back may touch the operand, so bus writes must drop
  chk_operand_held: assert property (busy_ff && !done_w |=>
    rf_ff[tgt_ff] == $past(rf_ff[tgt_ff]) && flags_ff == $past(flags_ff))
    else $error("operand or flags changed mid-instruction");
  chk_err_clear: assert property (start_w |=> !bad_opc_ff && !bad_dst_ff)
    else $error("error bits not cleared by a valid start");

  // Bus side: one-cycle ack, data zero outside it, writes land
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_read_idle: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");
  chk_cmd_echo: assert property (cmd_wr_w |=> cmd_ff == $past({dst_w, opc_w}))
    else $error("command register not updated");
  chk_flags_write: assert property (wr_ok_w && sel_flags_w |=>
    flags_ff == $past(flags_s'(wb_dat_i[7:0])))
    else $error("flag write lost");

  // Start is taken at one edge; busy is seen low seven edges later
  cov_plain_slot: cover property (start_w && opc_w == OPC_ROTL_SLOT ##7 !busy_ff);
  cov_plain_ptr: cover property (start_w && opc_w == OPC_ROTL_PTR ##7 !busy_ff);
  cov_carry_slot: cover property (start_w && opc_w == OPC_ROTC_SLOT ##7 !busy_ff);
  cov_carry_ptr: cover property (start_w && opc_w == OPC_ROTC_PTR ##7 !busy_ff);
  cov_bad_opc: cover property (cmd_wr_w && !opc_ok_w);
endmodule : rotate_left_unit

`default_nettype wire

/* File: pkg/rotl_pkg.sv */
/*
  Constants, register map and flag layout for the rotate-left datapath slice.
  Assumes a 32-bit classic Wishbone bus with word-aligned byte addresses.
*/
package rotl_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_WREG_BASE = 8'h40;
  localparam logic [1:0] OFS_WREG_TOP = 2'h1;

  // Command fields
  localparam int unsigned CMD_OPC_LSB = 0;
  localparam int unsigned CMD_DST_LSB = 8;

  // Status bit positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_BAD_OPC = 1;
  localparam int unsigned ST_BAD_DST = 2;

  // Opcodes
  localparam logic [7:0] OPC_ROTL_SLOT = 8'h90;
  localparam logic [7:0] OPC_ROTL_PTR = 8'h91;
  localparam logic [7:0] OPC_ROTC_SLOT = 8'h10;
  localparam logic [7:0] OPC_ROTC_PTR = 8'h11;

  // Short working-register operand marker
  localparam logic [3:0] WREG_MARK = 4'he;

  // Execution time
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned EXEC_CYCLES = 6;
  localparam logic [2:0] EXEC_LAST = 3'(EXEC_CYCLES - 1);

  // Flag byte: C Z V S D H and two spare bits
  typedef struct packed {
    logic c;
    logic z;
    logic v;
    logic s;
    logic d;
    logic h;
    logic [1:0] spare;
  } flags_s;

  localparam flags_s FLAGS_RST = flags_s'(8'h00);
endpackage : rotl_pkg

/* File: tb/wb_host.sv */
/*
  Classic Wishbone master standing in for the core's decoder side.
  Assumes a slave that acks within a few cycles on clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module wb_host (
  // Clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  // Request
  output logic cyc_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o
);
  logic hang = 1'b0;
  initial begin
    cyc_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    // Ack and read data are taken at one rising edge, then released there
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 40);
    q = rdat_i;
    hang = hang | (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    // Released lines must not keep the old value
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : xfer
endmodule : wb_host
`default_nettype wire

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the rotate-left slice.
  Assumes wb_host as bus master and the package constants.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import rotl_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, cyc, we, ack, busy;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q, r, seed = 32'd81;
  int fail_count = 0, compares = 0, tests = 0;
  logic [7:0] ops [4] = '{OPC_ROTL_SLOT, OPC_ROTL_PTR, OPC_ROTC_SLOT, OPC_ROTC_PTR};
  initial forever #10 clk_i = ~clk_i;
  rotate_left_unit rotate_left_unit_i (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy));
  wb_host wb_host_i (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .we_o(we),
    .adr_o(adr), .dat_o(wdat));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Result byte then flag byte; D, H and spare bits carried over
  function automatic logic [15:0] exp_rot(logic [7:0] op, logic [7:0] v, logic [7:0] f);
    logic [7:0] res;
    res = {v[6:0], op[7] ? v[7] : f[7]};
    return {res, v[7], res == 8'h00, res[7] ^ v[7], res[7], f[3:0]};
  endfunction : exp_rot
  task automatic print_verdict();
    if (wb_host_i.hang) begin
      fail_count++;
    end
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic cmp8(logic [7:0] got, logic [7:0] exp, string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp8
  task automatic run(logic [7:0] op, logic [3:0] n, logic [7:0] v, logic [7:0] f);
    logic [3:0] p;
    logic [15:0] e;
    int c;
    p = op[0] ? n + 4'h1 : n;
    e = exp_rot(op, v, f);
    c = 0;
    if (op[0]) wb_host_i.xfer(1'b1, OFS_WREG_BASE + {2'b00, n, 2'b00}, {24'h0, f[7:4], p}, q);
    wb_host_i.xfer(1'b1, OFS_WREG_BASE + {2'b00, p, 2'b00}, {24'h0, v}, q);
    wb_host_i.xfer(1'b1, OFS_FLAGS, {24'h0, f}, q);
    wb_host_i.xfer(1'b1, OFS_CMD, {16'h0, WREG_MARK, n, op}, q);
    while (busy === 1'b1 && c < 20) begin
      @(negedge clk_i);
      c++;
    end
    // Busy rose one edge before the ack was taken; c counts to its fall
    cmp8(8'(c), 8'(EXEC_CYCLES), "busy cycles");
    wb_host_i.xfer(1'b0, OFS_WREG_BASE + {2'b00, p, 2'b00}, 32'h0, q);
    cmp8(q[7:0], e[15:8], "result");
    wb_host_i.xfer(1'b0, OFS_FLAGS, 32'h0, q);
    cmp8(q[7:0], e[7:0], "flags");
    if (op[0]) begin
      wb_host_i.xfer(1'b0, OFS_WREG_BASE + {2'b00, n, 2'b00}, 32'h0, q);
      cmp8(q[7:0], {f[7:4], p}, "pointer register");
    end
    tests++;
    $display("test %0d done op %h", tests, op);
    if (wb_host_i.hang || c >= 20) begin
      print_verdict();
    end
  endtask : run
  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    run(OPC_ROTL_SLOT, 4'h3, 8'h88, 8'h00);
    run(OPC_ROTC_SLOT, 4'h6, 8'h8f, 8'h0c);
    run(OPC_ROTC_PTR, 4'hf, 8'h00, 8'h00);
    run(OPC_ROTL_PTR, 4'h0, 8'h40, 8'h80);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      run(ops[r[1:0]], r[11:8], r[23:16], r[31:24]);
    end
    wb_host_i.xfer(1'b1, OFS_CMD, {16'h0, 4'h5, 4'h2, OPC_ROTL_SLOT}, q);
    wb_host_i.xfer(1'b0, OFS_STATUS, 32'h0, q);
    cmp8(q[7:0], 8'(1 << ST_BAD_DST), "bad operand status");
    wb_host_i.xfer(1'b1, OFS_CMD, {16'h0, WREG_MARK, 4'h2, 8'h92}, q);
    wb_host_i.xfer(1'b0, OFS_STATUS, 32'h0, q);
    cmp8(q[7:0], 8'(1 << ST_BAD_OPC), "bad opcode status");
    wb_host_i.xfer(1'b0, 8'h3c, 32'h0, q);
    cmp8(q[7:0], 8'h00, "unmapped read");
    tests++;
    $display("test %0d done bad commands", tests);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
